// [irq_pkg.sv]
// Constants for the two-level priority interrupt unit.
// Assumes one clock domain and an APB register port with 32-bit data.
package irq_pkg;

  // ----------------------------------------------------------------
  // Sources in fixed polling order, highest first
  // ----------------------------------------------------------------
  localparam int          NSRC         = 18;
  localparam int          NCELL        = 19;
  localparam int          NEXT         = 7;
  localparam int          NLVL_EXT     = 6;
  localparam logic [4:0]  SRC_EXT0     = 5'h00;
  localparam logic [4:0]  SRC_T0       = 5'h01;
  localparam logic [4:0]  SRC_EXT1     = 5'h02;
  localparam logic [4:0]  SRC_T1       = 5'h03;
  localparam logic [4:0]  SRC_UART     = 5'h04;
  localparam logic [4:0]  SRC_T2       = 5'h05;
  localparam logic [4:0]  SRC_WDT      = 5'h06;
  localparam logic [4:0]  SRC_IFC      = 5'h07;
  localparam logic [4:0]  SRC_ADC      = 5'h08;
  localparam logic [4:0]  SRC_EXT2     = 5'h09;
  localparam logic [4:0]  SRC_EXT3     = 5'h0a;
  localparam logic [4:0]  SRC_EXT4     = 5'h0b;
  localparam logic [4:0]  SRC_S1       = 5'h0c;
  localparam logic [4:0]  SRC_S2       = 5'h0d;
  localparam logic [4:0]  SRC_EXT5     = 5'h0e;
  localparam logic [4:0]  SRC_EXT6     = 5'h0f;
  localparam logic [4:0]  SRC_T3       = 5'h10;
  localparam logic [4:0]  SRC_T45      = 5'h11;
  localparam logic [4:0]  CELL_UART_TX = 5'h12;

  // External request number to polling index
  localparam logic [4:0]  EXT_SRC [NEXT] = '{SRC_EXT0, SRC_EXT1, SRC_EXT2, SRC_EXT3,
                                             SRC_EXT4, SRC_EXT5, SRC_EXT6};
  // Timer overflow input number to polling index
  localparam logic [4:0]  TMR_SRC [5]    = '{SRC_T0, SRC_T1, SRC_T2, SRC_T3, SRC_T45};

  // ----------------------------------------------------------------
  // Vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_BASE     = 16'h0003;
  localparam int          VEC_SHIFT    = 3;

  // ----------------------------------------------------------------
  // Register byte offsets and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_REQ_A    = 8'h00;
  localparam logic [7:0]  OFS_REQ_B    = 8'h04;
  localparam logic [7:0]  OFS_EN_A     = 8'h08;
  localparam logic [7:0]  OFS_EN_B     = 8'h0c;
  localparam logic [7:0]  OFS_EN_C     = 8'h10;
  localparam logic [7:0]  OFS_PRI_A    = 8'h14;
  localparam logic [7:0]  OFS_PRI_B    = 8'h18;
  localparam logic [7:0]  OFS_PRI_C    = 8'h1c;
  localparam logic [7:0]  OFS_TRIG     = 8'h20;
  localparam logic [7:0]  OFS_CTRL     = 8'h24;
  localparam logic [7:0]  OFS_STATUS   = 8'h28;
  localparam int          REQ_A_CELLS  = 10;
  localparam int          REQ_B_CELLS  = 9;
  localparam int          GLOBAL_BIT   = 7;
  localparam int          NMI_BIT      = 0;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [17:0] EN_RST       = 18'h00000;
  localparam logic [17:0] PRI_RST      = 18'h00000;
  localparam logic [5:0]  TRIG_RST     = 6'h00;
  localparam logic        GLOBAL_RST   = 1'b0;
  localparam logic        NMI_RST      = 1'b0;

endpackage

// [irq_flag_cell.sv]
// One interrupt request flag with hardware and software set/clear paths.
// Assumes all controls are synchronous to CLK_IN and single-cycle pulses.
`timescale 1ns/1ns
module irq_flag_cell (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic level_in,
  input  wire logic pin_in,
  input  wire logic set_in,
  input  wire logic sw_we_in,
  input  wire logic sw_val_in,
  input  wire logic hw_clr_in,
  output logic      flag_out
);

  typedef struct packed {
    logic flag;
  } cell_state_t;

  cell_state_t q;
  cell_state_t d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // level source tracks pin
  always_comb begin
    d = q;
    if (level_in) begin
      d.flag = sw_we_in ? sw_val_in : pin_in;  // Write lasts until next clock
    end else if (set_in) begin
      d.flag = 1'b1;                            // Event wins over any clear
    end else if (sw_we_in) begin
      d.flag = sw_val_in;
    end else if (hw_clr_in) begin
      d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign flag_out = q.flag;

  AST_CELL_SET_WINS: assert property (@(posedge clk_in) disable iff (rst_in)
    set_in && !level_in |=> flag_out)
    else $error("Flag lost an event that arrived with a clear");

endmodule

// [irq_controller.sv]
// Two-level priority interrupt controller with APB registers and a core call port.
// Assumes MC_TICK_IN pulses once per machine cycle at the sample point and that the
// core flags the final cycle of each instruction and the return-from-interrupt.
`timescale 1ns/1ns
// Behaviour
// - Eighteen sources: seven external pins, eleven on-chip peripheral events.
// - External 0..5 level or edge by config bits; external 6 edge only.
// - On vectoring clear external flag only if edge mode; level flags follow pin.
// - Timer overflow flags set on rollover, cleared by hardware on vectoring.
// - UART request is receive OR transmit flag; serial flags left for software.
// - IF counter, converter, watchdog flags kept; watchdog may be non-maskable.
// - Software set or clear of a flag acts exactly like hardware.
// - Per-source enable bits in three registers plus one global enable.
// - Per-source priority bit; low preempted only by high, high never.
// - Pending requests of both levels: the high level one is served.
// - Equal level simultaneous requests resolved by fixed polling order.
// - Polling order external 0 first through timers 4/5 last.
// - Flags sampled each machine cycle, polled next cycle, call unless blocked.
// - No call while equal or higher level service is in progress.
// - No call unless polling cycle is the instruction's last cycle.
// - After return-from-interrupt or enable/priority write, one more instruction runs.
// - Blocked requests are not remembered; each poll uses fresh samples.
// - Call pushes program counter only; vector 0003H plus eight per order position.
// - Return-from-interrupt ends the current level's service.
module irq_controller (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [6:0]  EXT_REQ_IN,
  input  wire logic [4:0]  TIMER_OVF_IN,
  input  wire logic        UART_RX_DONE_IN,
  input  wire logic        UART_TX_DONE_IN,
  input  wire logic [1:0]  SERIAL_DONE_IN,
  input  wire logic        FREQ_COUNT_DONE_IN,
  input  wire logic        CONVERTER_DONE_IN,
  input  wire logic        WATCHDOG_EVENT_IN,
  input  wire logic        MC_TICK_IN,
  input  wire logic        LAST_CYCLE_IN,
  input  wire logic        RETURN_FROM_INTERRUPT_INSTR_IN,
  input  wire logic        CALL_ACK_IN,
  output logic             CALL_REQ_OUT,
  output logic [15:0]      VECTOR_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [17:0] en;
    logic [17:0] pri;
    logic        global_en;
    logic [5:0]  trig;
    logic        nmi;
    logic [17:0] sample;
    logic [6:0]  ext_prev;
    logic        req;
    logic [15:0] vec;
    logic [4:0]  sel;
    logic        sel_hi;
    logic        busy_hi;
    logic        busy_lo;
    logic        block;
    logic [31:0] rdata;
  } ctl_state_t;

  ctl_state_t  q;
  ctl_state_t  d;
  logic [18:0] cell_level;
  logic [18:0] cell_pin;
  logic [18:0] cell_set;
  logic [18:0] cell_we;
  logic [18:0] cell_wval;
  logic [18:0] cell_clr;
  logic [18:0] flag;
  logic [17:0] src_flag;
  logic [17:0] edge_mode;
  logic [17:0] pend;
  logic [17:0] hi;
  logic [17:0] lo;
  logic        acc;
  logic        wr;
  logic        mapped;
  logic        ctl_wr;
  logic        can_poll;

  // Lowest set index is the highest in the polling order
  function automatic logic [4:0] first_set(input logic [17:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = irq_pkg::NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  // one flag per source, two for the UART (receive and transmit)
  genvar g;
  generate
    for (g = 0; g < irq_pkg::NCELL; g++) begin : g_cell
      irq_flag_cell u_cell (
        .clk_in    (CLK_IN),
        .rst_in    (RST_IN),
        .level_in  (cell_level[g]),
        .pin_in    (cell_pin[g]),
        .set_in    (cell_set[g]),
        .sw_we_in  (cell_we[g]),
        .sw_val_in (cell_wval[g]),
        .hw_clr_in (cell_clr[g]),
        .flag_out  (flag[g])
      );
    end
  endgenerate

  // UART source is receive OR transmit
  always_comb begin
    src_flag = flag[17:0];
    src_flag[irq_pkg::SRC_UART] = flag[irq_pkg::SRC_UART] | flag[irq_pkg::CELL_UART_TX];
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Reads are captured in setup, so the slave answers in the first access cycle
  assign acc     = PSEL & PENABLE;
  assign wr      = acc & PWRITE;
  assign PREADY  = acc;
  assign PSLVERR = acc & ~mapped;
  assign PRDATA  = q.rdata;
  assign ctl_wr  = wr & (PADDR inside {irq_pkg::OFS_EN_A, irq_pkg::OFS_EN_B, irq_pkg::OFS_EN_C,
                                       irq_pkg::OFS_PRI_A, irq_pkg::OFS_PRI_B,
                                       irq_pkg::OFS_PRI_C});
  assign mapped  = PADDR inside {irq_pkg::OFS_REQ_A, irq_pkg::OFS_REQ_B, irq_pkg::OFS_EN_A,
                                 irq_pkg::OFS_EN_B, irq_pkg::OFS_EN_C, irq_pkg::OFS_PRI_A,
                                 irq_pkg::OFS_PRI_B, irq_pkg::OFS_PRI_C, irq_pkg::OFS_TRIG,
                                 irq_pkg::OFS_CTRL, irq_pkg::OFS_STATUS};

  // ----------------------------------------------------------------
  // Flag controls
  // ----------------------------------------------------------------
  always_comb begin
    cell_level = '0;
    cell_pin   = '0;
    cell_set   = '0;
    cell_we    = '0;
    cell_wval  = '0;
    cell_clr   = '0;
    edge_mode  = '0;
    for (int e = 0; e < irq_pkg::NEXT; e++) begin
      edge_mode[irq_pkg::EXT_SRC[e]] = (e < irq_pkg::NLVL_EXT) ? q.trig[e % irq_pkg::NLVL_EXT]
                                                              : 1'b1;  // Last pin edge only
      cell_level[irq_pkg::EXT_SRC[e]] = ~edge_mode[irq_pkg::EXT_SRC[e]];
      cell_pin[irq_pkg::EXT_SRC[e]]   = EXT_REQ_IN[e];
      cell_set[irq_pkg::EXT_SRC[e]]   = EXT_REQ_IN[e] & ~q.ext_prev[e];
    end
    for (int t = 0; t < 5; t++) begin
      cell_set[irq_pkg::TMR_SRC[t]] = TIMER_OVF_IN[t];
      edge_mode[irq_pkg::TMR_SRC[t]] = 1'b1;       // Timers are always cleared on call
    end
    cell_set[irq_pkg::SRC_UART]     = UART_RX_DONE_IN;
    cell_set[irq_pkg::CELL_UART_TX] = UART_TX_DONE_IN;
    cell_set[irq_pkg::SRC_S1]       = SERIAL_DONE_IN[0];
    cell_set[irq_pkg::SRC_S2]       = SERIAL_DONE_IN[1];
    cell_set[irq_pkg::SRC_IFC]      = FREQ_COUNT_DONE_IN;
    cell_set[irq_pkg::SRC_ADC]      = CONVERTER_DONE_IN;
    cell_set[irq_pkg::SRC_WDT]      = WATCHDOG_EVENT_IN;
    if (wr && PADDR == irq_pkg::OFS_REQ_A) begin
      cell_we[irq_pkg::REQ_A_CELLS-1:0]   = '1;
      cell_wval[irq_pkg::REQ_A_CELLS-1:0] = PWDATA[irq_pkg::REQ_A_CELLS-1:0];
    end
    if (wr && PADDR == irq_pkg::OFS_REQ_B) begin
      cell_we[irq_pkg::NCELL-1:irq_pkg::REQ_A_CELLS]   = '1;
      cell_wval[irq_pkg::NCELL-1:irq_pkg::REQ_A_CELLS] = PWDATA[irq_pkg::REQ_B_CELLS-1:0];
    end
    if (q.req && CALL_ACK_IN && edge_mode[q.sel]) begin
      cell_clr[q.sel] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // enables and global gate
  // watchdog bypasses the gates in non-maskable mode
  always_comb begin
    pend = q.sample & q.en & {irq_pkg::NSRC{q.global_en}};
    if (q.nmi) begin
      pend[irq_pkg::SRC_WDT] = q.sample[irq_pkg::SRC_WDT];
    end
    hi = pend & q.pri;
    lo = pend & ~q.pri;
  end

  // blocked after return or control write
  assign can_poll = MC_TICK_IN & LAST_CYCLE_IN & ~q.req & ~q.block & ~RETURN_FROM_INTERRUPT_INSTR_IN & ~ctl_wr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.ext_prev = EXT_REQ_IN;
    d.sample = MC_TICK_IN ? src_flag : q.sample;
    if (can_poll) begin
      if (|hi && !q.busy_hi) begin
        d.req    = 1'b1;
        d.sel    = first_set(hi);
        d.sel_hi = 1'b1;
      end else if (|lo && !q.busy_hi && !q.busy_lo) begin
        d.req    = 1'b1;
        d.sel    = first_set(lo);
        d.sel_hi = 1'b0;
      end
    end
    // vector base plus eight per slot
    d.vec = irq_pkg::VEC_BASE + {8'h00, d.sel, 3'h0};
    if (q.req && CALL_ACK_IN) begin
      d.req     = 1'b0;
      d.busy_hi = q.busy_hi | q.sel_hi;
      d.busy_lo = q.busy_lo | ~q.sel_hi;
    end
    if (RETURN_FROM_INTERRUPT_INSTR_IN && q.busy_hi) begin
      d.busy_hi = 1'b0;
    end else if (RETURN_FROM_INTERRUPT_INSTR_IN) begin
      d.busy_lo = 1'b0;
    end
    // hold until one more instruction ends
    d.block = RETURN_FROM_INTERRUPT_INSTR_IN | ctl_wr | (q.block & ~(MC_TICK_IN & LAST_CYCLE_IN));
    // Register writes
    if (wr) begin
      case (PADDR)
        irq_pkg::OFS_EN_A: begin
          d.en[5:0]   = PWDATA[5:0];
          d.global_en = PWDATA[irq_pkg::GLOBAL_BIT];
        end
        irq_pkg::OFS_EN_B:  d.en[11:6]   = PWDATA[5:0];
        irq_pkg::OFS_EN_C:  d.en[17:12]  = PWDATA[5:0];
        irq_pkg::OFS_PRI_A: d.pri[5:0]   = PWDATA[5:0];
        irq_pkg::OFS_PRI_B: d.pri[11:6]  = PWDATA[5:0];
        irq_pkg::OFS_PRI_C: d.pri[17:12] = PWDATA[5:0];
        irq_pkg::OFS_TRIG:  d.trig       = PWDATA[5:0];
        irq_pkg::OFS_CTRL:  d.nmi        = PWDATA[irq_pkg::NMI_BIT];
        default: ;
      endcase
    end
    // Read data captured in the setup phase
    if (PSEL && !PENABLE) begin
      case (PADDR)
        irq_pkg::OFS_REQ_A:  d.rdata = {22'h000000, flag[irq_pkg::REQ_A_CELLS-1:0]};
        irq_pkg::OFS_REQ_B:  d.rdata = {23'h000000, flag[irq_pkg::NCELL-1:irq_pkg::REQ_A_CELLS]};
        irq_pkg::OFS_EN_A:   d.rdata = {24'h000000, q.global_en, 1'b0, q.en[5:0]};
        irq_pkg::OFS_EN_B:   d.rdata = {26'h0000000, q.en[11:6]};
        irq_pkg::OFS_EN_C:   d.rdata = {26'h0000000, q.en[17:12]};
        irq_pkg::OFS_PRI_A:  d.rdata = {26'h0000000, q.pri[5:0]};
        irq_pkg::OFS_PRI_B:  d.rdata = {26'h0000000, q.pri[11:6]};
        irq_pkg::OFS_PRI_C:  d.rdata = {26'h0000000, q.pri[17:12]};
        irq_pkg::OFS_TRIG:   d.rdata = {26'h0000000, q.trig};
        irq_pkg::OFS_CTRL:   d.rdata = {31'h00000000, q.nmi};
        irq_pkg::OFS_STATUS: d.rdata = {q.vec, 6'h00, q.sel, q.block, q.sel_hi, q.busy_lo,
                                        q.busy_hi, q.req};
        default:             d.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      q           <= '0;
      q.en        <= irq_pkg::EN_RST;
      q.pri       <= irq_pkg::PRI_RST;
      q.global_en <= irq_pkg::GLOBAL_RST;
      q.trig      <= irq_pkg::TRIG_RST;
      q.nmi       <= irq_pkg::NMI_RST;
      q.vec       <= irq_pkg::VEC_BASE;
    end else begin
      q <= d;
    end
  end

  assign CALL_REQ_OUT = q.req;
  assign VECTOR_OUT   = q.vec;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  sequence s_call_start;
    $rose(CALL_REQ_OUT);
  endsequence
  sequence s_ack;
    CALL_REQ_OUT && CALL_ACK_IN;
  endsequence
  AST_CALL_HOLD: assert property (CALL_REQ_OUT && !CALL_ACK_IN |=>
    CALL_REQ_OUT && $stable(VECTOR_OUT))
    else $error("Call request or vector changed before acknowledge");
  AST_VECTOR_MAP: assert property (CALL_REQ_OUT |->
    VECTOR_OUT == irq_pkg::VEC_BASE + {8'h00, q.sel, 3'h0} && VECTOR_OUT <= 16'h008b)
    else $error("Vector does not match selected source");
  AST_LAST_CYCLE: assert property (s_call_start |->
    $past(MC_TICK_IN) && $past(LAST_CYCLE_IN))
    else $error("Call raised outside the final cycle of an instruction");
  AST_AFTER_RETURN: assert property (RETURN_FROM_INTERRUPT_INSTR_IN ##1 (!(MC_TICK_IN && LAST_CYCLE_IN)) [*1]
    |-> !CALL_REQ_OUT)
    else $error("Call raised directly after a return");
  AST_HIGH_EXCLUSIVE: assert property (s_call_start |-> !$past(q.busy_hi))
    else $error("Service at high level was preempted");
  AST_LOW_PREEMPT: assert property ((s_call_start and $past(q.busy_lo)) |-> q.sel_hi)
    else $error("Low level service preempted by low level request");
  AST_HIGH_WINS: assert property ((s_call_start and $past(|hi)) |-> q.sel_hi)
    else $error("Low level served while high level pending");
  AST_ORDER: assert property ((s_call_start and q.sel_hi) |->
    ($past(hi) & ((18'h00001 << q.sel) - 18'h00001)) == 18'h00000)
    else $error("Higher-order tie not chosen first");
  AST_EDGE_CLEAR: assert property ((s_ack and (edge_mode[q.sel] && !cell_set[q.sel]
    && !cell_we[q.sel] && q.sel != irq_pkg::SRC_UART)) |=> !flag[$past(q.sel)])
    else $error("Clearable flag survived the call");
  AST_LEVEL_FOLLOW: assert property (!q.trig[0] && !cell_we[irq_pkg::SRC_EXT0]
    |=> flag[irq_pkg::SRC_EXT0] == $past(EXT_REQ_IN[0]))
    else $error("Level source flag does not follow its pin");
  AST_SOFT_CLEAR_KEEPS: assert property ((s_ack and (q.sel == irq_pkg::SRC_S1
    && flag[irq_pkg::SRC_S1])) |=> flag[irq_pkg::SRC_S1])
    else $error("Serial flag cleared by hardware");
  AST_GLOBAL_OFF: assert property ((s_call_start and !$past(q.global_en))
    |-> q.sel == irq_pkg::SRC_WDT && $past(q.nmi))
    else $error("Call taken while globally disabled");
  AST_SAMPLE: assert property (MC_TICK_IN |=> q.sample == $past(src_flag))
    else $error("Flags not sampled at the machine tick");
  AST_RETURN_ENDS: assert property (RETURN_FROM_INTERRUPT_INSTR_IN && q.busy_hi && !(q.req && CALL_ACK_IN)
    |=> !q.busy_hi ##1 q.busy_lo == $past(q.busy_lo, 2))
    else $error("Return did not end high level service");
endmodule

// [core_model.sv]
// Core sequencer model: machine-cycle ticks, call acknowledge, return pulse.
// Assumes a registered call request that holds until acknowledged.
`timescale 1ns/1ns
module core_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        call_req_in,
  input  wire logic [15:0] vector_in,
  input  wire logic        slow_in,
  input  wire logic        return_from_interrupt_instr_cmd_in,
  output logic             tick_out,
  output logic             ack_out,
  output logic             return_from_interrupt_instr_out,
  output logic [15:0]      taken_vec_out,
  output logic [7:0]       taken_cnt_out
);
  logic [1:0] phase_q;
  logic [2:0] wait_q;
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // acknowledge when call starts
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_q       <= 2'h0;
      wait_q        <= 3'h0;
      tick_out      <= 1'b0;
      ack_out       <= 1'b0;
      return_from_interrupt_instr_out      <= 1'b0;
      taken_vec_out <= 16'h0000;
      taken_cnt_out <= 8'h00;
    end else begin
      phase_q  <= phase_q + 2'h1;
      tick_out <= (phase_q == 2'h2);
      return_from_interrupt_instr_out <= return_from_interrupt_instr_cmd_in;
      ack_out  <= 1'b0;
      // Slow mode stalls the acknowledge to show the request holds
      if (call_req_in && !ack_out) begin
        wait_q <= wait_q + 3'h1;
        if (!slow_in || wait_q == 3'h5) begin
          ack_out       <= 1'b1;
          taken_vec_out <= vector_in;
          taken_cnt_out <= taken_cnt_out + 8'h01;
          wait_q        <= 3'h0;
        end
      end
    end
  end
endmodule

// [test_two_level_priority_interrupt_unit.sv]
// Testbench for the interrupt controller: APB tasks plus a core model.
// Assumes zero-wait APB and a four-clock machine cycle from the model.
`timescale 1ns/1ns
module test_two_level_priority_interrupt_unit;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, last = 1, slow = 0, rcmd = 0, wdt = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, tick, ack, return_from_interrupt_instr, creq;
  logic [6:0]  ext = 7'h00;
  logic [4:0]  tmr = 5'h00;
  logic [15:0] vec, tvec;
  logic [7:0]  tcnt, c0;
  int          n_mismatch = 0, checked = 0;
  // ----------------------------------------
  // Clock, design and core model
  // ----------------------------------------
  initial forever #25 clk = ~clk;
  irq_controller dut_u (.CLK_IN(clk), .RST_IN(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_REQ_IN(ext), .TIMER_OVF_IN(tmr), .UART_RX_DONE_IN(1'b0),
    .UART_TX_DONE_IN(1'b0), .SERIAL_DONE_IN(2'h0), .FREQ_COUNT_DONE_IN(1'b0),
    .CONVERTER_DONE_IN(1'b0), .WATCHDOG_EVENT_IN(wdt), .MC_TICK_IN(tick),
    .LAST_CYCLE_IN(last), .RETURN_FROM_INTERRUPT_INSTR_IN(return_from_interrupt_instr), .CALL_ACK_IN(ack), .CALL_REQ_OUT(creq),
    .VECTOR_OUT(vec));
  core_model core_u (.clk_in(clk), .rst_in(rst), .call_req_in(creq), .vector_in(vec),
    .slow_in(slow), .return_from_interrupt_instr_cmd_in(rcmd), .tick_out(tick), .ack_out(ack), .return_from_interrupt_instr_out(return_from_interrupt_instr),
    .taken_vec_out(tvec), .taken_cnt_out(tcnt));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Hold the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge clk); tmr <= m;
    @(posedge clk); tmr <= 5'h00;
  endtask
  task automatic ret();
    @(posedge clk); rcmd <= 1;
    @(posedge clk); rcmd <= 0;
  endtask
  // Wait a bounded time for one call and check its vector
  task automatic expect_call(input logic [15:0] v, input logic r);
    c0 = tcnt;
    for (int i = 0; i < 200 && tcnt === c0; i++) @(posedge clk);
    cmp(tcnt, c0 + 8'h01);
    cmp(tvec, v);
    if (r) ret();
  endtask
  task automatic expect_none();
    c0 = tcnt;
    repeat (40) @(posedge clk);
    cmp(tcnt, c0);
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------
  initial begin
    #(50 * 20000);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    cmp(vec, 16'h0003);
    apb(0, 8'h08, 0); cmp(rd, 0);
    apb(0, 8'h30, 0); cmp(er, 1);
    apb(1, 8'h08, 32'h3f); apb(1, 8'h0c, 32'h3f); apb(1, 8'h10, 32'h3f);
    pulse(5'h01); expect_none();
    apb(1, 8'h08, 32'hbf); expect_call(16'h000b, 1);
    apb(0, 8'h00, 0); cmp(rd, 0);
    slow <= 1;
    pulse(5'h11); expect_call(16'h000b, 1);
    expect_call(16'h008b, 1);
    slow <= 0;
    apb(1, 8'h1c, 32'h20);
    pulse(5'h11); expect_call(16'h008b, 1);
    expect_call(16'h000b, 1);
    pulse(5'h01); expect_call(16'h000b, 0);
    pulse(5'h10); expect_call(16'h008b, 1);
    ret();
    apb(1, 8'h04, 32'h4); expect_call(16'h0063, 0);
    apb(0, 8'h04, 0); cmp(rd, 32'h4);
    apb(1, 8'h04, 0); apb(0, 8'h04, 0); cmp(rd, 0);
    ret();
    last <= 0;
    pulse(5'h01); expect_none();
    last <= 1; expect_call(16'h000b, 1);
    apb(1, 8'h20, 32'h1);
    ext <= 7'h01; expect_call(16'h0003, 0);
    apb(0, 8'h00, 0); cmp(rd, 0);
    ext <= 7'h00; ret();
    // Non-maskable watchdog still calls with the global gate off
    apb(1, 8'h24, 32'h1); apb(1, 8'h08, 32'h3f);
    wdt <= 1; @(posedge clk); wdt <= 0;
    expect_call(16'h0033, 0);
    apb(0, 8'h00, 0); cmp(rd, 32'h40);
    apb(1, 8'h00, 0); ret();
    wrap_up();
  end
endmodule
